// ---- rtl/aps_regs.vh ----
// constants for the arbitrary pulse segment 5..7 register bank
// assumes an axi4-lite slave with 32-bit data, one register per word
`ifndef APS_REGS_VH
`define APS_REGS_VH

// ============================================================
// register indices (byte address is four times the index)
`define APS_SEG5_IDX 6'h0c
`define APS_SEG6_IDX 6'h0d
`define APS_SEG7_IDX 6'h0e
`define APS_STAT_IDX 6'h1f

// ============================================================
// field layout of a segment register
`define APS_SEG_RESET 8'h00
`define APS_SIGN_BIT 6
`define APS_MAG_MSB 5
`define APS_RSVD_BIT 7

// ============================================================
// status register fields
`define APS_STAT_MODE_BIT 0
`define APS_STAT_ACTIVE_BIT 1
`define APS_STAT_IDX_LSB 2
`define APS_STAT_IDX_MSB 4

// ============================================================
// pulse segmentation
`define APS_NUM_SEGS 8
`define APS_LAST_SEG 3'h7
`define APS_SEG5_POS 3'h4
`define APS_SEG6_POS 3'h5
`define APS_SEG7_POS 3'h6

// ============================================================
// axi responses
`define APS_RESP_OKAY 2'h0
`define APS_RESP_SLVERR 2'h2

`endif

// ---- rtl/aps_seg_reg.v ----
// one 8-bit read/write segment amplitude register
// assumes a one-cycle write strobe from the bus slave on the same clock
`timescale 1ns/1ps
`include "aps_regs.vh"

module aps_seg_reg (
  aclk,
  aresetn,
  we,
  wdata,
  q
);
  input wire aclk;
  input wire aresetn;
  input wire we;
  input wire [7:0] wdata;
  output reg [7:0] q;

  // all eight bits kept, reserved bit included
  always @(posedge aclk) begin
    if (!aresetn) begin
      q <= `APS_SEG_RESET;
    end else if (we) begin
      q <= wdata;
    end
  end
endmodule // aps_seg_reg

// ---- rtl/aps_sm_decode.v ----
// signed-magnitude segment code to two's complement amplitude
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "aps_regs.vh"

module aps_sm_decode (
  code,
  enable,
  amp
);
  input wire [6:0] code;
  input wire enable;
  output reg [7:0] amp;

  reg [7:0] mag;

  always @* begin
    mag = {2'b00, code[`APS_MAG_MSB:0]};
    if (!enable) begin
      amp = 8'h00; // R02
    end else if (mag == 8'h00) begin
      amp = 8'h00; // R07
    end else if (code[`APS_SIGN_BIT]) begin
      amp = ~mag + 8'h01; // R03
    end else begin
      amp = mag; // R03
    end
  end
endmodule // aps_sm_decode

// ---- rtl/aps_top.v ----
// arbitrary transmit pulse: segment 5..7 amplitude registers and sequencer
// assumes axi4-lite master on aclk; mode select, segment strobes and
// start of pulse come from logic on the same clock
//
// How it works
// R01: a pulse is stepped through eight segments spanning one master period.
// R02: programmed amplitudes drive the pulse only in arbitrary pulse mode.
// R03: each 7-bit code is signed magnitude, bit 6 sign, bits 5..0 magnitude.
// R04: segment five takes bits 6..0 of register 01100, bit 7 reserved rw.
// R05: segment six takes bits 6..0 of register 01101, bit 7 reserved rw.
// R06: segment seven takes bits 6..0 of register 01110, bit 7 reserved rw.
// R07: zero magnitude is zero amplitude, and readback returns every bit.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "aps_regs.vh"

module aps_top (
  aclk,
  aresetn,
  s_axi_awaddr,
  s_axi_awprot,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arprot,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  arb_mode_en,
  pulse_start,
  seg_step,
  seg5_amplitude,
  seg6_amplitude,
  seg7_amplitude,
  seg_index,
  seg_active,
  drive_own,
  drive_amplitude
);
  input wire aclk;
  input wire aresetn;
  input wire [7:0] s_axi_awaddr;
  input wire [2:0] s_axi_awprot;
  input wire s_axi_awvalid;
  output wire s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output wire s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [7:0] s_axi_araddr;
  input wire [2:0] s_axi_arprot;
  input wire s_axi_arvalid;
  output wire s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  input wire arb_mode_en;
  input wire pulse_start;
  input wire seg_step;
  output reg [7:0] seg5_amplitude;
  output reg [7:0] seg6_amplitude;
  output reg [7:0] seg7_amplitude;
  output reg [2:0] seg_index;
  output reg seg_active;
  output reg drive_own;
  output reg [7:0] drive_amplitude;

  // ============================================================
  // write channel: address and data captured in either order
  reg aw_held_r;
  reg [5:0] aw_idx_r;
  reg aw_bad_r;
  reg w_held_r;
  reg [7:0] w_byte_r;
  reg w_lane0_r;
  wire do_write;
  wire we5;
  wire we6;
  wire we7;
  wire aw_hit5;
  wire aw_hit6;
  wire aw_hit7;
  wire aw_hit_stat;
  wire aw_mapped;

  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // a misaligned address hits nothing and is answered with slverr
  assign aw_hit5 = !aw_bad_r && (aw_idx_r == `APS_SEG5_IDX); // R04
  assign aw_hit6 = !aw_bad_r && (aw_idx_r == `APS_SEG6_IDX); // R05
  assign aw_hit7 = !aw_bad_r && (aw_idx_r == `APS_SEG7_IDX); // R06
  assign aw_hit_stat = !aw_bad_r && (aw_idx_r == `APS_STAT_IDX);
  assign aw_mapped = aw_hit5 || aw_hit6 || aw_hit7 || aw_hit_stat;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_idx_r <= 6'h00;
      aw_bad_r <= 1'b0;
      w_held_r <= 1'b0;
      w_byte_r <= 8'h00;
      w_lane0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `APS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[7:2];
        aw_bad_r <= (s_axi_awaddr[1:0] != 2'b00);
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (!aw_mapped) begin
          s_axi_bresp <= `APS_RESP_SLVERR;
        end else begin
          s_axi_bresp <= `APS_RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // a clear lane-0 strobe leaves the register untouched
  assign we5 = do_write && w_lane0_r && aw_hit5; // R04
  assign we6 = do_write && w_lane0_r && aw_hit6; // R05
  assign we7 = do_write && w_lane0_r && aw_hit7; // R06

  // ============================================================
  // segment registers
  wire [7:0] seg5_q;
  wire [7:0] seg6_q;
  wire [7:0] seg7_q;

  aps_seg_reg u_seg5 (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(we5),
    .wdata(w_byte_r),
    .q(seg5_q)
  );

  aps_seg_reg u_seg6 (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(we6),
    .wdata(w_byte_r),
    .q(seg6_q)
  );

  aps_seg_reg u_seg7 (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(we7),
    .wdata(w_byte_r),
    .q(seg7_q)
  );

  // ============================================================
  // read channel: one cycle from address to data
  reg [31:0] rd_nxt;
  reg [1:0] rresp_nxt;
  wire ar_bad;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_bad = (s_axi_araddr[1:0] != 2'b00);

  always @* begin
    rd_nxt = 32'h0000_0000;
    rresp_nxt = `APS_RESP_OKAY;
    if (ar_bad) begin
      rresp_nxt = `APS_RESP_SLVERR;
    end else begin
      case (s_axi_araddr[7:2])
        `APS_SEG5_IDX: rd_nxt = {24'h00_0000, seg5_q}; // R07
        `APS_SEG6_IDX: rd_nxt = {24'h00_0000, seg6_q}; // R07
        `APS_SEG7_IDX: rd_nxt = {24'h00_0000, seg7_q}; // R07
        // status word: mode, pulse busy, current segment
        `APS_STAT_IDX: begin
          rd_nxt[`APS_STAT_MODE_BIT] = arb_mode_en;
          rd_nxt[`APS_STAT_ACTIVE_BIT] = seg_active;
          rd_nxt[`APS_STAT_IDX_MSB:`APS_STAT_IDX_LSB] = seg_index;
        end
        default: rresp_nxt = `APS_RESP_SLVERR;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `APS_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_nxt;
      s_axi_rresp <= rresp_nxt;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ============================================================
  // amplitude decode
  wire [7:0] amp5;
  wire [7:0] amp6;
  wire [7:0] amp7;

  aps_sm_decode u_dec5 (
    .code(seg5_q[6:0]),
    .enable(arb_mode_en),
    .amp(amp5)
  );

  aps_sm_decode u_dec6 (
    .code(seg6_q[6:0]),
    .enable(arb_mode_en),
    .amp(amp6)
  );

  aps_sm_decode u_dec7 (
    .code(seg7_q[6:0]),
    .enable(arb_mode_en),
    .amp(amp7)
  );

  // ============================================================
  // segment sequencer, eight steps per master period
  reg [7:0] drive_nxt;
  reg own_nxt;
  wire seg_last;

  assign seg_last = (seg_index == `APS_LAST_SEG);

  // a start wins over a step that arrives in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      seg_active <= 1'b0;
      seg_index <= 3'h0;
    end else if (pulse_start) begin
      seg_active <= 1'b1; // R01
      seg_index <= 3'h0;
    end else if (seg_step && seg_active) begin
      if (seg_last) begin
        seg_active <= 1'b0; // R01
        seg_index <= 3'h0;
      end else begin
        seg_index <= seg_index + 3'h1; // R01
      end
    end
  end

  always @* begin
    drive_nxt = 8'h00;
    own_nxt = seg_active && arb_mode_en; // R02
    case (seg_index)
      `APS_SEG5_POS: drive_nxt = amp5; // R04
      `APS_SEG6_POS: drive_nxt = amp6; // R05
      `APS_SEG7_POS: drive_nxt = amp7; // R06
      default: own_nxt = 1'b0;
    endcase
    if (!own_nxt) begin
      drive_nxt = 8'h00;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      seg5_amplitude <= 8'h00;
      seg6_amplitude <= 8'h00;
      seg7_amplitude <= 8'h00;
      drive_own <= 1'b0;
      drive_amplitude <= 8'h00;
    end else begin
      seg5_amplitude <= amp5; // R02
      seg6_amplitude <= amp6; // R02
      seg7_amplitude <= amp7; // R02
      drive_own <= own_nxt;
      drive_amplitude <= drive_nxt;
    end
  end
endmodule // aps_top

// ---- testbench/aps_top_assertions.sv ----
// checker for the segment 5..7 register bank and its sequencer
// assumes a bind to aps_top, one clock, sync active-low reset
`timescale 1ns/1ps

module aps_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire arb_mode_en,
  input wire pulse_start,
  input wire seg_step,
  input wire [7:0] seg5_amplitude,
  input wire [7:0] seg6_amplitude,
  input wire [7:0] seg7_amplitude,
  input wire [2:0] seg_index,
  input wire seg_active,
  input wire drive_own,
  input wire [7:0] drive_amplitude
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ============================================================
  // sequencer
  chk_start_first: assert property (
    pulse_start |=> seg_active && seg_index == 3'h0)
    else $error("start missed segment one");
  chk_step_next: assert property (
    seg_active && seg_step && !pulse_start && seg_index != 3'h7
    |=> seg_index == $past(seg_index) + 3'h1)
    else $error("step did not advance");
  chk_wrap_end: assert property (
    seg_active && seg_step && !pulse_start && seg_index == 3'h7
    |=> !seg_active && seg_index == 3'h0)
    else $error("pulse did not end after eight");
  chk_own_seg: assert property (
    drive_own == $past(seg_active && arb_mode_en &&
    seg_index inside {3'h4, 3'h5, 3'h6}))
    else $error("own segment drive wrong");
  chk_own_zero: assert property (
    !drive_own |-> drive_amplitude == 8'h00)
    else $error("amplitude driven outside own segments");
  chk_mode_off: assert property (!arb_mode_en |=>
    {seg5_amplitude, seg6_amplitude, seg7_amplitude} == 24'h00_0000)
    else $error("amplitude used outside arbitrary mode");
  // ============================================================
  // bus holds
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  cover property (drive_own);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (seg_active && seg_step && seg_index == 3'h7);
endmodule // aps_chk

bind aps_top aps_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .arb_mode_en,
  .pulse_start, .seg_step, .seg5_amplitude, .seg6_amplitude, .seg7_amplitude,
  .seg_index, .seg_active, .drive_own, .drive_amplitude);

// ---- testbench/arbitrary_pulse_segment_regs_tb.sv ----
// self-checking bench for the segment 5..7 register bank
// assumes aps_top alone, driven over axi4-lite and the sequencer pins
`timescale 1ns/1ps
`include "aps_regs.vh"

module arbitrary_pulse_segment_regs_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, arb_mode_en;
  logic pulse_start, seg_step, seg_active, drive_own;
  logic [7:0] s_axi_awaddr, s_axi_araddr, drive_amplitude;
  logic [7:0] seg5_amplitude, seg6_amplitude, seg7_amplitude;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] seg_index;
  logic [7:0] val [0:2];
  logic [7:0] amp [0:3];
  integer fails, total_checks, i, k;

  aps_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .arb_mode_en, .pulse_start, .seg_step, .seg5_amplitude,
    .seg6_amplitude, .seg7_amplitude, .seg_index, .seg_active, .drive_own,
    .drive_amplitude);

  // ============================================================
  // helpers
  function [7:0] ad(input integer n);
    ad = {`APS_SEG5_IDX + 6'(n), 2'h0};
  endfunction

  task cmp(input [33:0] g, input [33:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task wrap_up;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task tmo;
    fails = fails + 1;
    $display("BAD %0t bus timeout", $time);
    wrap_up;
  endtask

  task wr(input [7:0] a, input [31:0] d, input [3:0] st, input [1:0] er);
    integer n;
    logic bd;
    bd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 40 && !bd; n = n + 1) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        bd = 1;
        s_axi_bready <= 1'h0;
        cmp(s_axi_bresp, er);
      end else if (s_axi_bvalid) s_axi_bready <= 1'h1;
    end
    if (!bd) tmo;
  endtask

  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    integer n;
    logic rv;
    rv = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 40 && !rv; n = n + 1) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        rv = 1;
        s_axi_rready <= 1'h0;
        cmp({s_axi_rresp, s_axi_rdata}, {er, e});
      end else if (s_axi_rvalid) s_axi_rready <= 1'h1;
    end
    if (!rv) tmo;
  endtask

  // ============================================================
  // clock and tests
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    fails = 0;
    total_checks = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
      arb_mode_en, pulse_start, seg_step, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    val = '{8'hc5, 8'h40, 8'h3f};
    amp = '{8'hfb, 8'h00, 8'h3f, 8'h00};
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (i = 0; i < 3; i = i + 1) rd(ad(i), 32'h0, 2'h0);
    for (i = 0; i < 3; i = i + 1)
      wr(ad(i), {24'ha5_a5a5, val[i]}, 4'h1, 2'h0);
    for (i = 0; i < 3; i = i + 1) rd(ad(i), 32'(val[i]), 2'h0);
    $display("register access done");
    cmp({seg5_amplitude, seg6_amplitude, seg7_amplitude}, 0);
    arb_mode_en <= 1'h1;
    repeat (2) @(posedge aclk);
    cmp({seg5_amplitude, seg6_amplitude, seg7_amplitude},
      {amp[0], amp[1], amp[2]});
    $display("decode done");
    wr(ad(0), 32'h0000_0011, 4'h0, 2'h0);
    rd(ad(0), 32'(val[0]), 2'h0);
    wr(8'h40, 32'h0000_0011, 4'h1, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    rd(8'h31, 32'h0, 2'h2);
    wr({`APS_STAT_IDX, 2'h0}, 32'h0000_00ff, 4'h1, 2'h0);
    rd({`APS_STAT_IDX, 2'h0}, 32'(1 << `APS_STAT_MODE_BIT), 2'h0);
    $display("refusals done");
    pulse_start <= 1'h1;
    for (k = 0; k < 8; k = k + 1) begin
      @(posedge aclk);
      pulse_start <= 1'h0;
      seg_step <= 1'h0;
      repeat (2) @(posedge aclk);
      cmp({seg_active, seg_index}, {1'h1, 3'(k)});
      cmp({drive_own, drive_amplitude},
        (k > 3 && k < 7) ? {1'h1, amp[k % 4]} : 9'h000);
      seg_step <= 1'h1;
    end
    @(posedge aclk);
    seg_step <= 1'h0;
    @(posedge aclk);
    cmp({seg_active, seg_index}, 4'h0);
    arb_mode_en <= 1'h0;
    repeat (2) @(posedge aclk);
    cmp({seg5_amplitude, seg6_amplitude, seg7_amplitude}, 0);
    $display("sequencer done");
    wrap_up;
  end
endmodule // arbitrary_pulse_segment_regs_tb
